// ==== verilog/rtc_ym_pkg.sv ====
package rtc_ym_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_WINDOW = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int WIN_LOW_LSB = 0;
    localparam int WIN_HIGH_LSB = 8;
    localparam int CTRL_WREN_BIT = 0;
    localparam int CTRL_PTR_LSB = 8;
    localparam int PTR_W = 2;
    localparam logic [1:0] PTR_YEAR = 2'h3;
    localparam logic [1:0] PTR_MONTH = 2'h2;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam logic WREN_RESET = 1'b0;
    // ------------------------------------------------------------
    // Digit layout and byte lanes
    // ------------------------------------------------------------
    localparam int YEAR_TENS_LSB = 4;
    localparam int MONTH_TENS_BIT = 4;
    localparam int DIGIT_W = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_N = 4;
    localparam int LANE_WIN_LOW = 0;
    localparam int LANE_WIN_HIGH = 1;
    localparam int LANE_CTRL_WREN = 0;
    localparam int LANE_CTRL_PTR = 1;
endpackage

// ==== verilog/rtc_year_month_value_regs.sv ====
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rtc_year_month_value_regs
    import rtc_ym_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Calendar values
    output logic [7:0] YEAR_VALUE,
    output logic [7:0] MONTH_VALUE
);
    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    typedef struct packed {
        logic clock_write_enable;
        logic [PTR_W-1:0] value_pointer;
        logic [31:0] rdata;
        logic slverr;
    } ctrl_t;

    // Calendar bytes kept apart: no reset on them
    typedef struct packed {
        logic [DIGIT_W-1:0] year_tens_digit;
        logic [DIGIT_W-1:0] year_ones_digit;
        logic month_tens_digit;
        logic [DIGIT_W-1:0] month_ones_digit;
    } cal_t;

    ctrl_t ctrl_ff;
    ctrl_t nxt_ctrl;
    cal_t cal_ff;
    cal_t nxt_cal;

    // ------------------------------------------------------------
    // Bus phase signals
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic wr;

    // ------------------------------------------------------------
    // Address and lane signals
    // ------------------------------------------------------------
    logic hit_window;
    logic hit_ctrl;
    logic hit_none;
    logic [LANE_N-1:0] lane_wr;

    // ------------------------------------------------------------
    // Pointer and write qualifiers
    // ------------------------------------------------------------
    logic ptr_is_year;
    logic ptr_is_month;
    logic year_wr;
    logic month_wr;
    logic wren_wr;
    logic ptr_wr;

    // ------------------------------------------------------------
    // Write data fields
    // ------------------------------------------------------------
    logic [DIGIT_W-1:0] wr_year_tens;
    logic [DIGIT_W-1:0] wr_year_ones;
    logic wr_month_tens;
    logic [DIGIT_W-1:0] wr_month_ones;
    logic wr_wren;
    logic [PTR_W-1:0] wr_ptr;

    // ------------------------------------------------------------
    // Read path signals
    // ------------------------------------------------------------
    logic [7:0] year_byte;
    logic [7:0] month_byte;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    logic [31:0] window_word;
    logic [31:0] ctrl_word;
    logic [31:0] read_word;

    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    always_comb begin
        setup = PSEL && !PENABLE;
        access = PSEL && PENABLE;
    end

    // Writes land only in access, where pready is always high
    always_comb begin
        wr = access && PWRITE;
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Any other offset answers with an error
    always_comb begin
        hit_window = 1'b0;
        hit_ctrl = 1'b0;
        hit_none = 1'b0;
        case (PADDR)
            ADDR_WINDOW: begin
                hit_window = 1'b1;
            end
            ADDR_CTRL: begin
                hit_ctrl = 1'b1;
            end
            default: begin
                hit_none = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    // A lane is written only with its strobe set
    for (genvar lane = 0; lane < LANE_N; lane++) begin : g_lane
        assign lane_wr[lane] = wr && PSTRB[lane];
    end

    // ------------------------------------------------------------
    // Pointer decode
    // ------------------------------------------------------------
    always_comb begin
        ptr_is_year = ctrl_ff.value_pointer == PTR_YEAR;
    end

    always_comb begin
        ptr_is_month = ctrl_ff.value_pointer == PTR_MONTH;
    end

    // ------------------------------------------------------------
    // Calendar write qualifiers
    // ------------------------------------------------------------
    // Window writes need the enable
    always_comb begin
        year_wr = 1'b0;
        if (hit_window && ctrl_ff.clock_write_enable) begin
            year_wr = lane_wr[LANE_WIN_LOW] && ptr_is_year;
        end
    end

    always_comb begin
        month_wr = 1'b0;
        if (hit_window && ctrl_ff.clock_write_enable) begin
            month_wr = lane_wr[LANE_WIN_HIGH] && ptr_is_month;
        end
    end

    // ------------------------------------------------------------
    // Control write qualifiers
    // ------------------------------------------------------------
    // Never gated, or the enable could not be set again
    always_comb begin
        wren_wr = hit_ctrl && lane_wr[LANE_CTRL_WREN];
        ptr_wr = hit_ctrl && lane_wr[LANE_CTRL_PTR];
    end

    // ------------------------------------------------------------
    // Calendar write fields
    // ------------------------------------------------------------
    always_comb begin
        wr_year_tens = PWDATA[WIN_LOW_LSB + YEAR_TENS_LSB +: DIGIT_W];
        wr_year_ones = PWDATA[WIN_LOW_LSB +: DIGIT_W];
        // Upper three month bits dropped, never stored
        wr_month_tens = PWDATA[WIN_HIGH_LSB + MONTH_TENS_BIT];
        wr_month_ones = PWDATA[WIN_HIGH_LSB +: DIGIT_W];
    end

    // ------------------------------------------------------------
    // Control write fields
    // ------------------------------------------------------------
    always_comb begin
        wr_wren = PWDATA[CTRL_WREN_BIT];
        wr_ptr = PWDATA[CTRL_PTR_LSB +: PTR_W];
    end

    // ------------------------------------------------------------
    // Stored bytes
    // ------------------------------------------------------------
    // Digits are not checked for BCD legality
    always_comb begin
        year_byte = {cal_ff.year_tens_digit,
                     cal_ff.year_ones_digit};
    end

    // Pad bits are never stored
    always_comb begin
        month_byte = {3'h0,
                      cal_ff.month_tens_digit,
                      cal_ff.month_ones_digit};
    end

    // ------------------------------------------------------------
    // Value window decode
    // ------------------------------------------------------------
    always_comb begin
        low_byte = 8'h00;
        high_byte = 8'h00;
        if (ptr_is_year) begin
            low_byte = year_byte;
        end

        if (ptr_is_month) begin
            high_byte = month_byte;
        end
    end

    // ------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------
    always_comb begin
        window_word = 32'h0000_0000;
        window_word[WIN_LOW_LSB +: BYTE_W] = low_byte;
        window_word[WIN_HIGH_LSB +: BYTE_W] = high_byte;
    end

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_WREN_BIT] = ctrl_ff.clock_write_enable;
        ctrl_word[CTRL_PTR_LSB +: PTR_W] = ctrl_ff.value_pointer;
    end

    // Unmapped offsets read as zero
    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_window) begin
            read_word = window_word;
        end

        if (hit_ctrl) begin
            read_word = ctrl_word;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cal = cal_ff;
        nxt_ctrl.rdata = 32'h0000_0000;
        nxt_ctrl.slverr = 1'b0;

        // Read answer captured in setup so access needs no wait
        if (setup) begin
            nxt_ctrl.rdata = read_word;
            nxt_ctrl.slverr = hit_none;
        end

        if (year_wr) begin
            nxt_cal.year_tens_digit = wr_year_tens;
            nxt_cal.year_ones_digit = wr_year_ones;
        end

        if (month_wr) begin
            nxt_cal.month_tens_digit = wr_month_tens;
            nxt_cal.month_ones_digit = wr_month_ones;
        end

        if (wren_wr) begin
            nxt_ctrl.clock_write_enable = wr_wren;
        end

        if (ptr_wr) begin
            nxt_ctrl.value_pointer = wr_ptr;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_ff.clock_write_enable <= WREN_RESET;
            ctrl_ff.value_pointer <= PTR_RESET;
            ctrl_ff.rdata <= 32'h0000_0000;
            ctrl_ff.slverr <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Calendar has no reset: software must load it first
    always_ff @(posedge CLK) begin
        cal_ff <= nxt_cal;
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Zero wait states: every access ends at once
    assign PREADY = 1'b1;

    // Outside access the bus sees zero, never stale data
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (access) begin
            PRDATA = ctrl_ff.rdata;
        end
    end

    always_comb begin
        PSLVERR = 1'b0;
        if (access) begin
            PSLVERR = ctrl_ff.slverr;
        end
    end

    // ------------------------------------------------------------
    // Calendar outputs
    // ------------------------------------------------------------
    always_comb begin
        YEAR_VALUE = year_byte;
        // Mask kept as a guard on the pad bits
        MONTH_VALUE = month_byte & MONTH_MASK;
    end
endmodule

// ==== sim/rtc_ym_monitor.sv ====
`timescale 1ns/1ps
module rtc_ym_monitor import rtc_ym_pkg::*; (
    // Bus and values
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic [7:0] YEAR_VALUE,
    input wire logic [7:0] MONTH_VALUE
);
    // Enable and pointer mirror; assumes full strobes
    logic [2:0] ctl_ff;
    wire win = PSEL && PENABLE && PADDR == ADDR_WINDOW;
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N) ctl_ff <= 3'h0;
        else if (PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL)
            ctl_ff <= {PWDATA[0], PWDATA[9:8]};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_w; win && PWRITE; endsequence
    sequence s_r; win && !PWRITE; endsequence
    property p_yw; s_w ##0 ctl_ff == 3'h7 |=>
        YEAR_VALUE == $past(PWDATA[7:0]); endproperty
    a_yw: assert property (p_yw) else $error("year");
    property p_yh; s_w ##0 !ctl_ff[2] |=> $stable(YEAR_VALUE); endproperty
    a_yh: assert property (p_yh) else $error("year");
    property p_mw; s_w ##0 ctl_ff == 3'h6 |=>
        MONTH_VALUE == ($past(PWDATA[15:8]) & MONTH_MASK); endproperty
    a_mw: assert property (p_mw) else $error("month");
    property p_mh; s_w ##0 !ctl_ff[2] |=> $stable(MONTH_VALUE); endproperty
    a_mh: assert property (p_mh) else $error("month");
    property p_yp; s_w ##0 ctl_ff[1:0] != 2'h3 |=> $stable(YEAR_VALUE);
    endproperty
    a_yp: assert property (p_yp) else $error("year");
    property p_mp; s_w ##0 ctl_ff[1:0] != 2'h2 |=> $stable(MONTH_VALUE);
    endproperty
    a_mp: assert property (p_mp) else $error("month");
    property p_yr; s_r ##0 ctl_ff[1:0] == 2'h3 |->
        PRDATA[7:0] == YEAR_VALUE; endproperty
    a_yr: assert property (p_yr) else $error("year");
    property p_mr; s_r ##0 ctl_ff[1:0] == 2'h2 |->
        PRDATA[15:8] == MONTH_VALUE; endproperty
    a_mr: assert property (p_mr) else $error("month");
    property p_mz; s_r |-> PRDATA[15:13] == 3'h0; endproperty
    a_mz: assert property (p_mz) else $error("month pad");
endmodule
bind rtc_year_month_value_regs rtc_ym_monitor mon (.*);

// ==== sim/rtc_year_month_value_regs_tb_top.sv ====
`timescale 1ns/1ps
module rtc_year_month_value_regs_tb_top import rtc_ym_pkg::*;;
    logic CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, PREADY, PSLVERR;
    logic [3:0] PSTRB = 4'hF;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [7:0] YEAR_VALUE, MONTH_VALUE;
    int fails = 0, cmp_count = 0, cyc = 0;
    always #4 CLK = ~CLK;
    rtc_year_month_value_regs dut (.*);
    task chk(input logic [15:0] got, exp);
        cmp_count++;
        fails += int'(got !== exp);
        if (got !== exp) $display("ERROR %0t %h %h", $time, got, exp);
    endtask
    // Bus left in access; next call starts setup at once
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
    endtask
    task report_and_stop;
        fails += int'(cyc >= 300);
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge CLK) if (++cyc == 300) report_and_stop;
    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h301);
        xfer(1'b1, ADDR_WINDOW, 32'h9959);
        xfer(1'b1, ADDR_CTRL, 32'h201);
        xfer(1'b1, ADDR_WINDOW, 32'hFF77);
        xfer(1'b1, ADDR_CTRL, 32'h200);
        xfer(1'b0, ADDR_WINDOW, 32'h0);
        chk(PRDATA[15:0], 16'h1F00);
        xfer(1'b1, ADDR_WINDOW, 32'h0100);
        xfer(1'b1, ADDR_CTRL, 32'h300);
        xfer(1'b1, ADDR_WINDOW, 32'h0012);
        xfer(1'b0, ADDR_WINDOW, 32'h0);
        chk(PRDATA[15:0], 16'h0059);
        chk({8'h00, MONTH_VALUE}, 16'h001F);
        xfer(1'b0, ADDR_CTRL, 32'h0);
        chk(PRDATA[15:0], 16'h0300);
        xfer(1'b0, 12'h008, 32'h0);
        chk({15'h0000, PSLVERR}, 16'h0001);
        chk(PRDATA[15:0], 16'h0000);
        report_and_stop;
    end
endmodule
